/* rtl/ufces_defines.vh */
`ifndef UFCES_DEFINES_VH
`define UFCES_DEFINES_VH
// register addresses
`define UFCES_ADDR_ENABLE    10'h000
`define UFCES_ADDR_FLOW      10'h006
`define UFCES_ADDR_RESUME    10'h007
`define UFCES_ADDR_PAUSE     10'h008
`define UFCES_ADDR_ERROR     10'h009
`define UFCES_ADDR_LINK      10'h262
// reset values
`define UFCES_RST_ENABLE     2'h0
`define UFCES_RST_FLOW       4'h0
`define UFCES_RST_RESUME     8'h11
`define UFCES_RST_PAUSE      8'h13
`define UFCES_RST_LINK       16'h0000
// enable fields
`define UFCES_EN_TX          0
`define UFCES_EN_RX          1
// flow mode fields
`define UFCES_FLOW_HDX       3
`define UFCES_MODE_HI        2
`define UFCES_MODE_NONE      3'h0
`define UFCES_MODE_HW        3'h1
`define UFCES_MODE_SW        3'h2
`define UFCES_MODE_MD_RX     3'h3
`define UFCES_MODE_MD_ALL    3'h4
// error fields
`define UFCES_ERR_BRK_NOW    7
`define UFCES_ERR_OVR        6
`define UFCES_ERR_PAR        5
`define UFCES_ERR_FRM        4
`define UFCES_ERR_BRK        3
`endif

/* rtl/ufces_fifo.v */
`timescale 1ns/1ps
module ufces_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap at the top so depth need not be a power of two
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

/* rtl/ufces_ctrl.v */
// Summary of operation
// (RULE1) software disables channel before most register writes
// (RULE2) enable bit1 receiver, bit0 transmitter, reset off
// (RULE3) flow mode written only while disabled
// (RULE4) half duplex drops receive data during transmit
// (RULE5) mode 000 no flow control, reset
// (RULE6) mode 001 hardware handshake flow control
// (RULE7) mode 010 pause/resume character flow control
// (RULE8) mode 011 receive after match, transmit free
// (RULE9) mode 100 both directions after match
// (RULE10) modes 101 to 111 reserved
// (RULE11) resume character restarts transmit, resets 0x11
// (RULE12) pause character stops transmit, resets 0x13
// (RULE13) nine-bit characters compare low eight only
// (RULE14) resume holds unicast, pause multicast address
// (RULE15) sticky line errors clear on read
// (RULE16) bit7 shows live break, not cleared
// (RULE17) bit6 overrun when buffer full
// (RULE18) bit5 parity error sticky
// (RULE19) bit4 missing stop bit sticky
// (RULE20) bit3 break seen sticky
// (RULE21) per-character errors need wide tagging mode
// (RULE22) software writes zero to reserved bits
// (RULE23) hardware flow holds next character while clear-to-send low
`timescale 1ns/1ps
`include "ufces_defines.vh"
module ufces_ctrl #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // vendor register requests
  input  wire        vendor_reg_write_request,
  input  wire        vendor_reg_read_request,
  input  wire        link_state_write_request,
  input  wire        link_state_read_request,
  input  wire [9:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // receiver character stream from the deserialiser
  input  wire        rx_char_valid,
  input  wire [8:0]  rx_char_data,
  input  wire        rx_char_nine_bit,
  input  wire        rx_char_addr_flag,
  input  wire        rx_parity_err,
  input  wire        rx_frame_err,
  input  wire        rx_break_now,
  input  wire        rx_break_start,
  input  wire        rx_buf_full,
  // filtered receive stream to the receive buffer
  output wire        rx_out_valid,
  input  wire        rx_out_ready,
  output wire [8:0]  rx_out_data,
  // transmitter side
  input  wire        tx_busy,
  input  wire        tx_char_end,
  input  wire        cts_in,
  output wire        tx_start_allow,
  // channel status
  output wire        tx_enable,
  output wire        rx_enable,
  output wire        half_duplex,
  output wire [2:0]  flow_mode,
  output wire        hw_flow_active,
  output wire        rx_overflow_drop
);
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  reg [1:0]  enable_reg;
  reg [3:0]  flow_reg;
  reg [7:0]  resume_reg;
  reg [7:0]  pause_reg;
  reg [15:0] link_reg;
  reg        ovr_reg;
  reg        par_reg;
  reg        frm_reg;
  reg        brk_reg;
  reg        tx_paused_reg;
  reg        addr_match_reg;
  reg        cts_hold_reg;
  wire       rst_n;
  wire       is_sw;
  wire       is_md;
  wire       err_read;
  wire       rx_gate;
  wire       rx_accept;
  wire       fifo_in_ready;
  wire       fifo_push;
  reg [2:0]  mode_sel;

  // reset released through two flops
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // character compare on the low eight bits; ninth bit taken as zero
  function match8;
    input [8:0] ch;
    input [7:0] ref_char;
    input       nine;
    begin
      match8 = (ch[7:0] == ref_char) & ~(nine & 1'b0); // (RULE13)
    end
  endfunction

  // reserved codes fall back to mode 000 behaviour
  always @* begin
    case (flow_reg[`UFCES_MODE_HI:0])
      `UFCES_MODE_NONE:   mode_sel = `UFCES_MODE_NONE; // (RULE5)
      `UFCES_MODE_HW:     mode_sel = `UFCES_MODE_HW;
      `UFCES_MODE_SW:     mode_sel = `UFCES_MODE_SW;
      `UFCES_MODE_MD_RX:  mode_sel = `UFCES_MODE_MD_RX;
      `UFCES_MODE_MD_ALL: mode_sel = `UFCES_MODE_MD_ALL;
      default:            mode_sel = `UFCES_MODE_NONE;
    endcase
  end

  assign tx_enable      = enable_reg[`UFCES_EN_TX]; // (RULE2)
  assign rx_enable      = enable_reg[`UFCES_EN_RX]; // (RULE2)
  assign half_duplex    = flow_reg[`UFCES_FLOW_HDX];
  assign flow_mode      = mode_sel;
  assign hw_flow_active = (mode_sel == `UFCES_MODE_HW); // (RULE6)
  assign is_sw          = (mode_sel == `UFCES_MODE_SW); // (RULE7)
  assign is_md          = (mode_sel == `UFCES_MODE_MD_RX) | (mode_sel == `UFCES_MODE_MD_ALL);
  assign err_read       = vendor_reg_read_request & (reg_addr == `UFCES_ADDR_ERROR);

  // half duplex: characters landing while transmitting are ignored
  assign rx_gate   = rx_char_valid & rx_enable & ~(half_duplex & tx_busy); // (RULE4)
  // multidrop: address characters update the match, data only after a match
  assign rx_accept = rx_gate & ~(is_md & (rx_char_addr_flag | ~addr_match_reg)) // (RULE8)
                     & ~(is_sw & (match8(rx_char_data, resume_reg, rx_char_nine_bit)
                     | match8(rx_char_data, pause_reg, rx_char_nine_bit)));
  assign fifo_push = rx_accept & fifo_in_ready;
  assign rx_overflow_drop = rx_accept & ~fifo_in_ready;

  // transmit gating: pause state, handshake hold, multidrop match
  assign tx_start_allow = tx_enable
                        & ~(is_sw & tx_paused_reg) // (RULE12)
                        & ~(hw_flow_active & cts_hold_reg) // (RULE23)
                        & ~((mode_sel == `UFCES_MODE_MD_ALL) & ~addr_match_reg); // (RULE9)

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= `UFCES_RST_ENABLE;
      flow_reg   <= `UFCES_RST_FLOW;
      resume_reg <= `UFCES_RST_RESUME;
      pause_reg  <= `UFCES_RST_PAUSE;
      link_reg   <= `UFCES_RST_LINK;
    end else begin
      // writes are taken as-is; gating on enable state is software's duty
      if (vendor_reg_write_request) begin
        case (reg_addr)
          `UFCES_ADDR_ENABLE: enable_reg <= reg_wdata[1:0];
          `UFCES_ADDR_FLOW:   flow_reg   <= reg_wdata[3:0];
          `UFCES_ADDR_RESUME: resume_reg <= reg_wdata[7:0];
          `UFCES_ADDR_PAUSE:  pause_reg  <= reg_wdata[7:0];
          default: begin
          end
        endcase
      end
      if (link_state_write_request) begin
        link_reg <= reg_wdata;
      end
    end
  end

  // sticky errors: a new event in the read cycle survives the clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovr_reg <= 1'b0;
      par_reg <= 1'b0;
      frm_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      ovr_reg <= (rx_char_valid & rx_buf_full) | (ovr_reg & ~err_read); // (RULE17)
      par_reg <= (rx_char_valid & rx_parity_err) | (par_reg & ~err_read); // (RULE18)
      frm_reg <= (rx_char_valid & rx_frame_err) | (frm_reg & ~err_read); // (RULE19)
      brk_reg <= rx_break_start | (brk_reg & ~err_read); // (RULE20)
    end
  end

  // flow state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_paused_reg  <= 1'b0;
      addr_match_reg <= 1'b0;
      cts_hold_reg   <= 1'b0;
    end else begin
      if (!is_sw) begin
        tx_paused_reg <= 1'b0;
      end else if (rx_gate & match8(rx_char_data, pause_reg, rx_char_nine_bit)) begin
        tx_paused_reg <= 1'b1; // (RULE12)
      end else if (rx_gate & match8(rx_char_data, resume_reg, rx_char_nine_bit)) begin
        tx_paused_reg <= 1'b0; // (RULE11)
      end
      if (!is_md) begin
        addr_match_reg <= 1'b0;
      end else if (rx_gate & rx_char_addr_flag) begin
        addr_match_reg <= match8(rx_char_data, resume_reg, rx_char_nine_bit)
                        | match8(rx_char_data, pause_reg, rx_char_nine_bit); // (RULE14)
      end
      // the hold only takes effect between characters
      if (!tx_busy | tx_char_end) begin
        cts_hold_reg <= ~cts_in; // (RULE23)
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= vendor_reg_read_request | link_state_read_request;
      if (link_state_read_request) begin
        reg_rdata <= link_reg;
      end else if (vendor_reg_read_request) begin
        case (reg_addr)
          `UFCES_ADDR_ENABLE: reg_rdata <= {14'h0000, enable_reg};
          `UFCES_ADDR_FLOW:   reg_rdata <= {12'h000, flow_reg};
          `UFCES_ADDR_RESUME: reg_rdata <= {8'h00, resume_reg};
          `UFCES_ADDR_PAUSE:  reg_rdata <= {8'h00, pause_reg};
          `UFCES_ADDR_ERROR:  reg_rdata <= {8'h00, rx_break_now, ovr_reg, par_reg, // (RULE16)
                                            frm_reg, brk_reg, 3'h0}; // (RULE15)
          default:            reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ufces_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rx_accept),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_char_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out_data)
  );
endmodule

/* bench/ufces_peer.sv */
`timescale 1ns/1ps
// local line transmitter gated by tx_start_allow: busy for CHAR_CYC cycles a character
module ufces_peer #(
  parameter [3:0] CHAR_CYC = 4'h4
) (
  // clock and reset
  input  wire clk_sys,
  input  wire rstn,
  // handshake with the block
  input  wire tx_go,
  input  wire tx_start_allow,
  output reg  tx_busy,
  output reg  tx_char_end
);
  reg [3:0] cnt_reg;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_busy <= 1'b0;
      tx_char_end <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      tx_char_end <= 1'b0;
      // start only when allowed, so a held character really waits
      if (!tx_busy && tx_go && tx_start_allow) begin
        tx_busy <= 1'b1;
        cnt_reg <= CHAR_CYC;
      end else if (tx_busy) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          tx_busy <= 1'b0;
          tx_char_end <= 1'b1;
        end
      end
    end
  end
endmodule

/* bench/ufces_ctrl_chk.sv */
`timescale 1ns/1ps
module ufces_ctrl_chk (
  // clock and reset
  input wire        clk_sys,
  input wire        rstn,
  // register requests
  input wire        vendor_reg_write_request,
  input wire        vendor_reg_read_request,
  input wire        link_state_read_request,
  input wire [9:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire        reg_rvalid,
  // character streams
  input wire        rx_char_valid,
  input wire        rx_break_now,
  input wire        rx_break_start,
  input wire        rx_out_valid,
  input wire        tx_busy,
  input wire        cts_in,
  input wire        tx_start_allow,
  // status
  input wire        tx_enable,
  input wire        rx_enable,
  input wire        half_duplex,
  input wire [2:0]  flow_mode,
  input wire        hw_flow_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire rd_err = vendor_reg_read_request && reg_addr == 10'h009;
  wire wr_en  = vendor_reg_write_request && reg_addr == 10'h000;
  // events at a read edge survive it, so only quiet reads may clear
  wire quiet  = !rx_char_valid && !rx_break_start;
  AST_RVALID: assert property (vendor_reg_read_request |=> reg_rvalid)
    else $error("read not answered");
  AST_NORV: assert property (!vendor_reg_read_request && !link_state_read_request
    |=> !reg_rvalid) else $error("answer without read");
  AST_TXEN: assert property (wr_en |=> tx_enable == $past(reg_wdata[0]))
    else $error("tx enable wrong");
  AST_RXEN: assert property (wr_en |=> rx_enable == $past(reg_wdata[1]))
    else $error("rx enable wrong");
  AST_HDX: assert property (half_duplex && tx_busy && rx_char_valid && !rx_out_valid
    |=> !rx_out_valid) else $error("rx kept during tx");
  AST_PASS: assert property (rx_enable && !half_duplex && flow_mode == 3'h0
    && rx_char_valid && !rx_out_valid |=> rx_out_valid) else $error("rx char lost");
  AST_BRKNOW: assert property (rd_err |=> reg_rdata[7] == $past(rx_break_now))
    else $error("live break wrong");
  AST_CLR: assert property ((rd_err && quiet) ##1 quiet ##1 (rd_err && quiet)
    |=> reg_rdata[6:3] == 4'h0) else $error("sticky not cleared");
  AST_CTS: assert property ((hw_flow_active && !cts_in && !tx_busy) [*2]
    |-> !tx_start_allow) else $error("start while cts low");
  C_RD: cover property (rd_err);
  C_HDX: cover property (half_duplex && tx_busy && rx_char_valid);
  C_CTS: cover property (hw_flow_active && !cts_in);
endmodule
bind ufces_ctrl ufces_ctrl_chk u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .vendor_reg_write_request(vendor_reg_write_request),
  .vendor_reg_read_request(vendor_reg_read_request),
  .link_state_read_request(link_state_read_request), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .rx_char_valid(rx_char_valid), .rx_break_now(rx_break_now),
  .rx_break_start(rx_break_start), .rx_out_valid(rx_out_valid), .tx_busy(tx_busy),
  .cts_in(cts_in), .tx_start_allow(tx_start_allow), .tx_enable(tx_enable),
  .rx_enable(rx_enable), .half_duplex(half_duplex), .flow_mode(flow_mode),
  .hw_flow_active(hw_flow_active));

/* bench/uart_flow_ctrl_error_status_test.sv */
`timescale 1ns/1ps
module uart_flow_ctrl_error_status_test;
  typedef struct packed {
    logic        w;
    logic [9:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } ufces_row_t;
  ufces_row_t rows [0:10];
  reg         clk_sys, rstn, wr_req, rd_req, lw_req, lr_req, rx_char_valid;
  reg         af, nine, pe, fe, bnow, bstart, bfull, rx_out_ready, cts_in, tx_go, drop;
  reg  [9:0]  reg_addr;
  reg  [15:0] reg_wdata;
  reg  [8:0]  rx_char_data;
  wire [15:0] reg_rdata;
  wire [8:0]  rx_out_data;
  wire [2:0]  flow_mode;
  wire        reg_rvalid, rx_out_valid, tx_start_allow, tx_enable, rx_enable;
  wire        half_duplex, hw_flow_active, rx_overflow_drop, tx_busy, tx_char_end;
  integer     error_cnt, compares, i;
  ufces_ctrl #(.FIFO_DEPTH(8), .FIFO_AW(3)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .vendor_reg_write_request(wr_req),
    .vendor_reg_read_request(rd_req), .link_state_write_request(lw_req),
    .link_state_read_request(lr_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_char_nine_bit(nine), .rx_char_addr_flag(af),
    .rx_parity_err(pe), .rx_frame_err(fe), .rx_break_now(bnow), .rx_break_start(bstart),
    .rx_buf_full(bfull), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
    .rx_out_data(rx_out_data), .tx_busy(tx_busy), .tx_char_end(tx_char_end),
    .cts_in(cts_in), .tx_start_allow(tx_start_allow), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .half_duplex(half_duplex), .flow_mode(flow_mode),
    .hw_flow_active(hw_flow_active), .rx_overflow_drop(rx_overflow_drop));
  ufces_peer u_peer (.clk_sys(clk_sys), .rstn(rstn), .tx_go(tx_go),
    .tx_start_allow(tx_start_allow), .tx_busy(tx_busy), .tx_char_end(tx_char_end));
  always #50 clk_sys = ~clk_sys;
  task finish_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input [15:0] s, input [15:0] e);
    compares = compares + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input [9:0] a, input [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    if (a == 10'h262) lw_req <= 1'b1;
    else wr_req <= 1'b1;
    @(posedge clk_sys);
    {wr_req, lw_req} <= 2'h0;
  endtask
  task rd(input [9:0] a, input [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    if (a == 10'h262) lr_req <= 1'b1;
    else rd_req <= 1'b1;
    @(posedge clk_sys);
    {rd_req, lr_req} <= 2'h0;
    @(negedge clk_sys);
    chk("rvalid", reg_rvalid, 16'h0001);
    chk("rdata", reg_rdata, e);
  endtask
  // f is {address mark, nine bit, parity, framing, buffer full}
  task snd(input [8:0] d, input [4:0] f);
    @(posedge clk_sys);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    {af, nine, pe, fe, bfull} <= f;
    @(negedge clk_sys);
    drop = rx_overflow_drop;
    @(posedge clk_sys);
    {rx_char_valid, af, nine, pe, fe, bfull} <= 6'h00;
    @(negedge clk_sys);
  endtask
  task pop;
    @(posedge clk_sys);
    rx_out_ready <= 1'b1;
    @(posedge clk_sys);
    rx_out_ready <= 1'b0;
    @(negedge clk_sys);
  endtask
  // disable first: mode changes are only safe on a stopped channel
  task mode(input [15:0] f);
    wr(10'h000, 16'h0000);
    wr(10'h006, f);
    wr(10'h000, 16'h0003);
  endtask
  initial begin
    #3000000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    {clk_sys, rstn, wr_req, rd_req, lw_req, lr_req, rx_char_valid, af, nine} = 9'h000;
    {pe, fe, bnow, bstart, bfull, rx_out_ready, tx_go, drop} = 8'h00;
    {cts_in, reg_addr, reg_wdata, rx_char_data, error_cnt, compares} = 0;
    cts_in = 1'b1;
    rows = '{'{0, 10'h000, 16'h0, 16'h0000}, '{0, 10'h006, 16'h0, 16'h0000},
      '{0, 10'h007, 16'h0, 16'h0011}, '{0, 10'h008, 16'h0, 16'h0013},
      '{0, 10'h009, 16'h0, 16'h0000}, '{0, 10'h262, 16'h0, 16'h0000},
      '{1, 10'h007, 16'h00AA, 16'h00AA}, '{1, 10'h006, 16'h000A, 16'h000A},
      '{1, 10'h262, 16'hA5C3, 16'hA5C3}, '{1, 10'h3FF, 16'hFFFF, 16'h0000},
      '{1, 10'h006, 16'h0000, 16'h0000}};
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("status", {tx_enable, rx_enable, half_duplex, flow_mode}, 16'h0000);
    for (i = 0; i < 11; i = i + 1) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(10'h000, 16'h0003);
    for (i = 0; i < 9; i = i + 1) snd(i, 5'h00);
    chk("drop", drop, 16'h0001);
    for (i = 0; i < 8; i = i + 1) begin
      chk("rxdata", rx_out_data, i);
      pop;
    end
    chk("empty", rx_out_valid, 16'h0000);
    @(posedge clk_sys);
    {bnow, bstart} <= 2'h3;
    @(posedge clk_sys);
    bstart <= 1'b0;
    snd(9'h000, 5'h06);
    snd(9'h000, 5'h01);
    rd(10'h009, 16'h00F8);
    rd(10'h009, 16'h0080);
    @(posedge clk_sys);
    bnow <= 1'b0;
    rd(10'h009, 16'h0000);
    pop;
    pop;
    mode(16'h0002);
    snd(9'h013, 5'h00);
    chk("allow", tx_start_allow, 16'h0000);
    chk("valid", rx_out_valid, 16'h0000);
    snd(9'h1AA, 5'h08);
    chk("allow", tx_start_allow, 16'h0001);
    mode(16'h0001);
    chk("hwflow", hw_flow_active, 16'h0001);
    @(posedge clk_sys);
    cts_in <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("allow", tx_start_allow, 16'h0000);
    @(posedge clk_sys);
    cts_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("allow", tx_start_allow, 16'h0001);
    mode(16'h0008);
    @(posedge clk_sys);
    tx_go <= 1'b1;
    @(posedge clk_sys);
    tx_go <= 1'b0;
    snd(9'h055, 5'h00);
    chk("valid", rx_out_valid, 16'h0000);
    repeat (6) @(posedge clk_sys);
    snd(9'h055, 5'h00);
    chk("valid", rx_out_valid, 16'h0001);
    pop;
    mode(16'h0003);
    snd(9'h055, 5'h00);
    snd(9'h0AA, 5'h10);
    chk("valid", rx_out_valid, 16'h0000);
    chk("allow", tx_start_allow, 16'h0001);
    snd(9'h042, 5'h00);
    chk("mdrx", {rx_out_valid, rx_out_data}, 16'h0242);
    pop;
    mode(16'h0004);
    snd(9'h077, 5'h10);
    chk("allow", tx_start_allow, 16'h0000);
    snd(9'h013, 5'h10);
    chk("allow", tx_start_allow, 16'h0001);
    // mid-run reset must bring back every reset value
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("status", {tx_enable, rx_enable, half_duplex, flow_mode}, 16'h0000);
    rd(10'h007, 16'h0011);
    rd(10'h008, 16'h0013);
    rd(10'h262, 16'h0000);
    finish_test;
  end
endmodule
